// ===== rtl/sram_burst_port.sv
// Pipelined zero-turnaround burst SRAM port with array
module sram_burst_port
   import sram_port_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           resetn,
   input  wire logic [sram_port_pkg::HIGH_W-1:0] address_high,
   input  wire logic                           burst_seed_high,
   input  wire logic                           burst_seed_low,
   input  wire logic                           addr_advance_or_load,
   input  wire logic                           read_write_n,
   input  wire logic                           byte_lane_write_first,
   input  wire logic                           byte_lane_write_second,
   input  wire logic                           byte_lane_write_third,
   input  wire logic                           byte_lane_write_fourth,
   input  wire logic                           chip_select_n,
   input  wire logic                           expansion_select_n,
   input  wire logic                           expansion_select,
   input  wire logic                           clock_gate_low,
   input  wire logic                           output_enable_n,
   input  wire logic                           burst_order,
   input  wire logic                           sleep_request,
   input  wire logic [sram_port_pkg::LANE_W-1:0] data_byte_lane_first_in,
   input  wire logic [sram_port_pkg::LANE_W-1:0] data_byte_lane_second_in,
   input  wire logic [sram_port_pkg::LANE_W-1:0] data_byte_lane_third_in,
   input  wire logic [sram_port_pkg::LANE_W-1:0] data_byte_lane_fourth_in,
   output logic      [sram_port_pkg::LANE_W-1:0] data_byte_lane_first_out,
   output logic      [sram_port_pkg::LANE_W-1:0] data_byte_lane_second_out,
   output logic      [sram_port_pkg::LANE_W-1:0] data_byte_lane_third_out,
   output logic      [sram_port_pkg::LANE_W-1:0] data_byte_lane_fourth_out,
   output logic                                data_oe
);
   import sram_port_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic                sleep_meta;
      logic                sleep_sync;
      logic                order_meta;
      logic                order_sync;
      logic                oe_n_meta;
      logic                oe_n_sync;
      access_e             burst_kind;
      logic [HIGH_W-1:0]   base_hi;
      logic [BURST_W-1:0]  seed;
      logic [BURST_W-1:0]  count;
      access_e             s1_kind;
      logic [ADDR_W-1:0]   s1_addr;
      logic [LANES-1:0]    s1_bw;
      access_e             s2_kind;
      logic [ADDR_W-1:0]   s2_addr;
      logic [LANES-1:0]    s2_bw;
      logic [DATA_W-1:0]   out_data;
      logic                out_valid;
      logic                drive;
   } port_s;

   port_s             st;
   port_s             next_st;
   logic [1:0]        rst_sync;
   logic              rst_n;
   logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
   logic              hold;
   logic              en;
   logic              load;
   logic              selected;
   logic [LANES-1:0]  bw_in;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] rd_word;
   logic [BURST_W-1:0] next_count;
   logic [BURST_W-1:0] burst_lo;
   logic              buf_in_valid;
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic              buf_out_ready;
   logic [DATA_W-1:0] buf_out_data;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // Cycle qualification
   // ----------------------------------------
   // stall on gate or sleep
   assign hold  = clock_gate_low | st.sleep_sync;
   assign en    = ~hold & buf_in_ready;
   assign load  = ~addr_advance_or_load;
   assign selected = ~chip_select_n & ~expansion_select_n & expansion_select;
   assign bw_in = {byte_lane_write_fourth, byte_lane_write_third,
                   byte_lane_write_second, byte_lane_write_first};
   assign wr_data = {data_byte_lane_fourth_in, data_byte_lane_third_in,
                     data_byte_lane_second_in, data_byte_lane_first_in};

   assign next_count = BURST_W'(st.count + COUNT_STEP);
   assign burst_lo   = (st.order_sync == ORDER_LINEAR) ? BURST_W'(st.seed + next_count)
                                                       : (st.seed ^ next_count);

   // ----------------------------------------
   // Array read with write bypass
   // ----------------------------------------
   always_comb begin
      rd_word = mem[st.s1_addr];
      if (st.s2_kind == ACC_WRITE && st.s2_addr == st.s1_addr) begin
         for (int i = 0; i < LANES; i++) begin
            if (!st.s2_bw[i]) begin
               rd_word[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   assign buf_in_valid  = ~hold & (st.s1_kind == ACC_READ);
   assign buf_out_ready = en & (st.s2_kind == ACC_READ);

   sram_word_buffer #(
      .WIDTH(DATA_W)
   ) read_buffer (
      .clk      (clk),
      .rst_n    (rst_n),
      .in_valid (buf_in_valid),
      .in_ready (buf_in_ready),
      .in_data  (rd_word),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data (buf_out_data)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.sleep_meta = sleep_request;
      next_st.sleep_sync = st.sleep_meta;
      next_st.order_meta = burst_order;
      next_st.order_sync = st.order_meta;
      next_st.oe_n_meta  = output_enable_n;
      next_st.oe_n_sync  = st.oe_n_meta;
      if (en) begin
         if (load) begin
            next_st.base_hi    = address_high;
            next_st.seed       = {burst_seed_high, burst_seed_low};
            next_st.count      = COUNT_RESET;
            next_st.burst_kind = !selected    ? ACC_IDLE :
                                 read_write_n ? ACC_READ : ACC_WRITE;
            next_st.s1_kind    = next_st.burst_kind;
            next_st.s1_addr    = {address_high, burst_seed_high, burst_seed_low};
         end else begin
            next_st.count   = next_count;
            next_st.s1_kind = st.burst_kind;
            next_st.s1_addr = {st.base_hi, burst_lo};
         end
         next_st.s1_bw   = bw_in;
         next_st.s2_kind = st.s1_kind;
         next_st.s2_addr = st.s1_addr;
         next_st.s2_bw   = st.s1_bw;
         if (st.s2_kind == ACC_READ) begin
            next_st.out_data = buf_out_data;
         end
         next_st.out_valid = (st.s2_kind == ACC_READ);
      end
      next_st.drive = next_st.out_valid & ~st.oe_n_sync & ~st.sleep_sync;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.seed    <= COUNT_RESET;
         st.s1_addr <= ADDR_RESET;
         st.s2_addr <= ADDR_RESET;
         st.s1_bw   <= LANES_OFF;
         st.s2_bw   <= LANES_OFF;
         st.out_data <= DATA_RESET;
         st.oe_n_meta <= 1'b1;
         st.oe_n_sync <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Array write
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (en && st.s2_kind == ACC_WRITE) begin
         for (int i = 0; i < LANES; i++) begin
            if (!st.s2_bw[i]) begin
               mem[st.s2_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign data_byte_lane_first_out  = st.out_data[0*LANE_W +: LANE_W];
   assign data_byte_lane_second_out = st.out_data[1*LANE_W +: LANE_W];
   assign data_byte_lane_third_out  = st.out_data[2*LANE_W +: LANE_W];
   assign data_byte_lane_fourth_out = st.out_data[3*LANE_W +: LANE_W];
   // drivers follow output enable without clock
   assign data_oe = st.out_valid & ~output_enable_n & ~st.sleep_sync;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_read_two_edges: assert property (
      en && load && selected && read_write_n ##1 en ##1 en |=> st.out_valid)
      else $error("read data not out after two enabled edges");
   chk_stall_holds: assert property (
      hold |=> $stable(st.s1_addr) && $stable(st.out_data) && $stable(st.count))
      else $error("state moved during stall");
   chk_sleep_holds: assert property (
      st.sleep_sync |=> $stable(st.s2_kind) && $stable(st.out_valid))
      else $error("state moved during sleep");
   chk_seed_load: assert property (
      en && load |=> st.s1_addr[1:0] == $past({burst_seed_high, burst_seed_low})
                     && st.count == COUNT_RESET)
      else $error("burst seed not loaded");
   chk_burst_step: assert property (
      en && !load |=> st.count == BURST_W'($past(st.count) + COUNT_STEP))
      else $error("burst counter did not step");
   chk_type_kept: assert property (
      en && !load |=> st.s1_kind == $past(st.burst_kind))
      else $error("access type changed on advance");
   chk_deselect_load: assert property (
      en && load && !selected |=> st.s1_kind == ACC_IDLE)
      else $error("deselected load became an access");
   chk_linear_order: assert property (
      en && !load && st.order_sync == ORDER_LINEAR
      |=> st.s1_addr[1:0] == BURST_W'($past(st.seed) + $past(st.count) + COUNT_STEP))
      else $error("linear burst address wrong");
   chk_oe_off: assert property (
      output_enable_n |-> !data_oe)
      else $error("driving with output enable high");
   chk_write_lane: assert property (
      en && st.s2_kind == ACC_WRITE && !st.s2_bw[0]
      |=> mem[$past(st.s2_addr)][LANE_W-1:0] == $past(data_byte_lane_first_in))
      else $error("first lane not written");
   chk_no_wait: assert property (
      !hold |-> buf_in_ready && (st.s2_kind != ACC_READ || buf_out_valid))
      else $error("wait cycle inserted");

   cov_read_burst: cover property (
      en && load && selected && read_write_n ##1 en && !load ##1 en && !load);
   cov_write_read: cover property (
      en && load && selected && !read_write_n ##1 en && load && selected && read_write_n);
   cov_stall: cover property (st.s2_kind == ACC_READ && clock_gate_low ##1 en);
endmodule

// ===== rtl/sram_port_pkg.sv
// Constants and types of the pipelined burst SRAM port
package sram_port_pkg;
   localparam int ADDR_W    = 20;
   localparam int DATA_W    = 36;
   localparam int LANES     = 4;
   localparam int LANE_W    = 9;
   localparam int BURST_W   = 2;
   localparam int HIGH_W    = ADDR_W - BURST_W;
   localparam int MEM_WORDS = 1 << ADDR_W;

   localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
   localparam logic [BURST_W-1:0] COUNT_STEP  = 2'h1;
   localparam logic [ADDR_W-1:0]  ADDR_RESET  = 20'h00000;
   localparam logic [DATA_W-1:0]  DATA_RESET  = 36'h000000000;
   localparam logic [LANES-1:0]   LANES_OFF   = 4'hF;
   localparam logic               ORDER_LINEAR = 1'b0;

   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_READ  = 2'b01,
      ACC_WRITE = 2'b10
   } access_e;
endpackage

// ===== rtl/sram_word_buffer.sv
// Two-entry word buffer with valid and ready on both sides
module sram_word_buffer #(
   parameter int WIDTH = 36
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] slot;
      logic                  rd;
      logic                  wr;
      logic [1:0]            count;
   } buf_s;

   buf_s st;
   buf_s next_st;
   logic push;
   logic pop;

   assign in_ready  = (st.count != 2'h2);
   assign out_valid = (st.count != 2'h0);
   assign out_data  = st.slot[st.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.slot[st.wr] = in_data;
         next_st.wr          = ~st.wr;
      end
      if (pop) begin
         next_st.rd = ~st.rd;
      end
      next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   chk_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
      st.count == 2'h2 |=> st.count != 2'h0 || $past(pop))
      else $error("buffer lost words");
endmodule

// ===== sim/pipelined_zero_turnaround_sram_port_bench.sv
// Self-checking bench for the burst SRAM port
module pipelined_zero_turnaround_sram_port_bench
   import sram_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic              advance, rw_n, cs_n, xs_n, xs, gate, oe_n, order, sleep, data_oe;
   logic [LANES-1:0]  bw_n;
   logic [DATA_W-1:0] wdata, rdata, ed;
   int                miscompares = 0;
   int                num_checks = 0;
   int                cycles = 0;
   int                hush = 0;
   int                seed = 32'h068FF149;
   logic [DATA_W-1:0] mem [int];
   access_e           act = ACC_IDLE;
   access_e           pa [2] = '{ACC_IDLE, ACC_IDLE};
   int                padr [2];
   logic [LANES-1:0]  pbw [2];
   logic [HIGH_W-1:0] base;
   logic [1:0]        sd, cnt;
   logic              ev = 1'b0;

   always #5 clk = ~clk;

   sram_host_model host (.addr(addr), .advance(advance), .rw_n(rw_n), .bw_n(bw_n),
      .cs_n(cs_n), .xs_n(xs_n), .xs(xs), .gate(gate), .oe_n(oe_n), .order(order),
      .sleep(sleep), .wdata(wdata));

   sram_burst_port dut (.clk(clk), .resetn(resetn), .address_high(addr[19:2]),
      .burst_seed_high(addr[1]), .burst_seed_low(addr[0]), .addr_advance_or_load(advance),
      .read_write_n(rw_n), .byte_lane_write_first(bw_n[0]), .byte_lane_write_second(bw_n[1]),
      .byte_lane_write_third(bw_n[2]), .byte_lane_write_fourth(bw_n[3]), .chip_select_n(cs_n),
      .expansion_select_n(xs_n), .expansion_select(xs), .clock_gate_low(gate),
      .output_enable_n(oe_n), .burst_order(order), .sleep_request(sleep),
      .data_byte_lane_first_in(wdata[8:0]), .data_byte_lane_second_in(wdata[17:9]),
      .data_byte_lane_third_in(wdata[26:18]), .data_byte_lane_fourth_in(wdata[35:27]),
      .data_byte_lane_first_out(rdata[8:0]), .data_byte_lane_second_out(rdata[17:9]),
      .data_byte_lane_third_out(rdata[26:18]), .data_byte_lane_fourth_out(rdata[35:27]),
      .data_oe(data_oe));

   // -----------------------------------
   // Reference model, one enabled edge
   // -----------------------------------
   function automatic void step();
      logic [1:0] lo;
      if (!advance) begin
         act = (cs_n | xs_n | !xs) ? ACC_IDLE : (rw_n ? ACC_READ : ACC_WRITE);
         {base, sd, cnt} = {addr, 2'h0};
      end else begin
         cnt = cnt + 2'h1;
      end
      lo = order ? (sd ^ cnt) : (sd + cnt);
      if (pa[1] == ACC_WRITE) begin
         for (int i = 0; i < LANES; i++) begin
            if (!pbw[1][i]) mem[padr[1]][i*LANE_W +: LANE_W] = wdata[i*LANE_W +: LANE_W];
         end
      end
      ev = (pa[1] == ACC_READ);
      if (ev) ed = mem[padr[1]];
      pa[1] = pa[0];
      {padr[1], pbw[1]} = {padr[0], pbw[0]};
      pa[0] = act;
      {padr[0], pbw[0]} = {int'({base, lo}), bw_n};
   endfunction

   task automatic check_oe(input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: drive expected %h got %h", $time, e, g);
      end
   endtask

   task automatic check_data(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: data expected %h got %h", $time, e, g);
      end
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // -----------------------------------
   // Stimulus
   // -----------------------------------
   task automatic cyc(input logic ld, input logic rw, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] bw, input logic [1:0] sel, input logic st,
                      input logic oe);
      logic [63:0] t;
      logic        w;
      t = {$random(seed), $random(seed)};
      w = ld ? (sel == 2'h0 && !rw) : (act == ACC_WRITE);
      host.issue(ld, rw, a, bw, sel, st, w, t[35:0]);
      host.set_oe(oe);
      #4;
      if (hush > 0) begin
         hush--;
      end else begin
         check_oe(ev & !oe_n & !sleep, data_oe); // drive control
         if (ev & !sleep) check_data(ed, rdata); // read data
      end
      @(posedge clk);
      if (!gate && !sleep) step();
      #1;
   endtask

   task automatic idle();
      cyc(1'b0, 1'b1, ADDR_RESET, LANES_OFF, 2'h0, 1'b1, 1'b0);
   endtask

   task automatic rnd_cyc(input logic may_stall);
      logic [31:0] r;
      r = $random(seed);
      cyc(r[1:0] == 2'h0, r[2], {16'hFFFF, r[6:3]}, r[10:7],
          (r[14:12] == 3'h0) ? r[16:15] : 2'h0, may_stall & (r[19:17] == 3'h0),
          r[21:20] == 2'h0);
   endtask

   task automatic do_reset(input logic ord);
      resetn = 1'b0;
      host.set_mode(ord, 1'b0);
      host.flush();
      ev = 1'b0;
      act = ACC_IDLE;
      pa[0] = ACC_IDLE;
      pa[1] = ACC_IDLE;
      for (int k = 0; k < 12; k++) begin
         if (k == 8) resetn = 1'b1;
         idle();
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      @(posedge clk);
      #1;
      do_reset(ORDER_LINEAR); // linear order
      for (int j = 0; j < 16; j++) begin
         cyc(j % 4 == 0, 1'b0, {16'hFFFF, 4'(j)}, 4'h0, 2'h0, 1'b0, 1'b0); // fill
      end
      repeat (600) rnd_cyc(1'b1); // mixed
      host.set_mode(ORDER_LINEAR, 1'b1); // enter sleep
      hush = 4;
      repeat (4) idle();
      repeat (8) rnd_cyc(1'b0); // inputs ignored
      host.set_mode(ORDER_LINEAR, 1'b0);
      hush = 4;
      repeat (4) idle();
      do_reset(1'b1); // interleaved order
      repeat (600) rnd_cyc(1'b1); // interleaved bursts
      close_out();
   end
endmodule

// ===== sim/sram_host_model.sv
// Controller model that drives the burst SRAM port pins
module sram_host_model
   import sram_port_pkg::*;
(
   output logic [sram_port_pkg::ADDR_W-1:0] addr,
   output logic                             advance,
   output logic                             rw_n,
   output logic [sram_port_pkg::LANES-1:0]  bw_n,
   output logic                             cs_n,
   output logic                             xs_n,
   output logic                             xs,
   output logic                             gate,
   output logic                             oe_n,
   output logic                             order,
   output logic                             sleep,
   output logic [sram_port_pkg::DATA_W-1:0] wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [DATA_W-1:0] pd [2];
   logic              pw [2];

   initial begin
      {addr, advance, rw_n, bw_n} = {ADDR_RESET, 1'b1, 1'b1, LANES_OFF};
      {cs_n, xs_n, xs, gate, oe_n} = 5'h1A;
      {order, sleep} = 2'h0;
      wdata = DATA_RESET;
      pw = '{1'b0, 1'b0};
   end

   // -----------------------------------
   // Pin driving
   // -----------------------------------
   task automatic issue(input logic ld, input logic rw, input logic [ADDR_W-1:0] a,
                        input logic [LANES-1:0] bw, input logic [1:0] sel, input logic st,
                        input logic w, input logic [DATA_W-1:0] d);
      gate = st;
      if (sleep) begin
         {addr, advance, rw_n, bw_n, wdata} = {a, !ld, rw, bw, d};
      end else if (!st) begin
         advance = !ld;
         rw_n = rw;
         addr = a;
         bw_n = bw;
         cs_n = (sel == 2'h1);
         xs_n = (sel == 2'h2);
         xs = (sel != 2'h3);
         wdata = pw[1] ? pd[1] : ~wdata;
         pw[1] = pw[0];
         pd[1] = pd[0];
         pw[0] = w;
         pd[0] = d;
      end
   endtask

   task automatic set_oe(input logic v);
      oe_n = v;
   endtask

   task automatic set_mode(input logic ord, input logic slp);
      order = ord;
      sleep = slp;
   endtask

   task automatic flush();
      pw = '{1'b0, 1'b0};
   endtask
endmodule
